//--- rtl/cbrsc_pkg.sv
/*
  constants, state codes and reset values for the card bridge reset and
  suspend controller.
  assumes: one clock, the host-bus clock, at 25 MHz.
*/
// ============================================================
// package
package cbrsc_pkg;

  localparam int unsigned CBRSC_CLK_MHZ     = 25;
  localparam int unsigned CBRSC_SYNC_STAGES = 2;

  localparam logic [1:0] CBRSC_VCC_SEL_RST = 2'h0;
  localparam logic [1:0] CBRSC_VPP_SEL_RST = 2'h0;
  localparam logic       CBRSC_PME_EN_RST  = 1'h0;
  localparam logic       CBRSC_PME_STS_RST = 1'h0;

  typedef enum logic [2:0] {
    CBRSC_ST_RESET = 3'b001,
    CBRSC_ST_RUN   = 3'b010,
    CBRSC_ST_SUSP  = 3'b100
  } cbrsc_state_e;

endpackage : cbrsc_pkg

//--- rtl/cbrsc_rst_sync.sv
/*
  reset synchroniser: asserts at once, releases after STAGES clock edges.
  assumes: arstIn_n may change at any time relative to clk.
*/
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// reset synchroniser
module cbrsc_rst_sync #(
  parameter int unsigned STAGES = 2
) (
  input  wire logic clk,
  input  wire logic arstIn_n,
  output logic      rstOut_n
);

  logic [STAGES-1:0] chain_q;

  if (STAGES < 2) begin : g_chk
    $error("cbrsc_rst_sync: STAGES must be at least 2");
  end

  always_ff @(posedge clk or negedge arstIn_n) begin
    if (!arstIn_n) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], 1'b1};
    end
  end

  assign rstOut_n = chain_q[STAGES-1];

endmodule : cbrsc_rst_sync

`default_nettype wire

//--- rtl/cbrsc_ctrl.sv
/*
  reset, suspend and card power-switch control of a bus-to-card bridge.
  assumes: all inputs synchronous to clk (the host-bus clock); the pads
  turn an output enable that is high into a floating pin.
*/
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// Operation
// - global reset without suspend floats every output and clears all registers.
// - with suspend active global reset is ignored, registers kept, outputs floated.
// - with suspend active host-bus reset is ignored, registers kept, outputs floated.
// - inputs are sampled on the rising host-bus clock edge, but the resets float the pins under pinOe_n and clear the sync chains asynchronously.
// - host-bus reset without suspend floats outputs and resets internal registers except the power-event enable and status.
// - during host-bus reset the power event pin is driven only if enabled earlier.
// - on host-bus reset release the block is in its default state, and ready one clock after the core sync chain has released.
// - a pair of outputs selects the card supply voltage at the power switch.
// - a second pair of outputs selects the card programming voltage.
module cbrsc_ctrl
  import cbrsc_pkg::*;
#(
  parameter int unsigned SYNC_STAGES = CBRSC_SYNC_STAGES
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       globalResetIn_n,
  input  wire logic       hostBusResetIn_n,
  input  wire logic       suspendIn_n,
  input  wire logic       powerLoad,
  input  wire logic [1:0] vccReq,
  input  wire logic [1:0] vppReq,
  input  wire logic       pmeEnableSet,
  input  wire logic       pmeEnableClr,
  input  wire logic       pmeEvent,
  input  wire logic       pmeStatusClr,
  output logic            cardVccSel0,
  output logic            cardVccSel1,
  output logic            cardVppSel0,
  output logic            cardVppSel1,
  output logic            pinOe_n,
  output logic            pmeOut_n,
  output logic            pmeOe_n,
  output logic            deviceReady
);

  if (SYNC_STAGES < 2 || SYNC_STAGES > 8) begin : g_chk
    $error("cbrsc_ctrl: SYNC_STAGES must lie in 2..8");
  end

  // ============================================================
  // reset derivation
  wire logic suspended = ~suspendIn_n;
  // suspend shields the core from both resets
  wire logic coreArst_n = resetn & (suspended | (globalResetIn_n & hostBusResetIn_n));
  // power-event context is cleared by global reset or resetn only, not by host-bus reset
  wire logic pmeArst_n  = resetn & (suspended | globalResetIn_n);
  logic      coreRst_n;
  logic      pmeRst_n;

  cbrsc_rst_sync #(.STAGES(SYNC_STAGES)) u_core_sync (
    .clk      (clk),
    .arstIn_n (coreArst_n),
    .rstOut_n (coreRst_n)
  );

  cbrsc_rst_sync #(.STAGES(SYNC_STAGES)) u_pme_sync (
    .clk      (clk),
    .arstIn_n (pmeArst_n),
    .rstOut_n (pmeRst_n)
  );

  // ============================================================
  // state
  cbrsc_state_e state_q;
  cbrsc_state_e state_d;
  logic [1:0]   vccSel_q;
  logic [1:0]   vppSel_q;
  logic         pmeEn_q;
  logic         pmeSts_q;

  wire logic canUpdate = coreRst_n & ~suspended;
  wire logic driveD    = coreArst_n & coreRst_n & ~suspended;
  wire logic pmeAssert = pmeEn_q & pmeSts_q;

  always_comb begin
    case (state_q)
      CBRSC_ST_RESET: state_d = suspended ? CBRSC_ST_SUSP : CBRSC_ST_RUN;
      CBRSC_ST_RUN:   state_d = suspended ? CBRSC_ST_SUSP : CBRSC_ST_RUN;
      CBRSC_ST_SUSP:  state_d = suspended ? CBRSC_ST_SUSP : CBRSC_ST_RUN;
      default:        state_d = CBRSC_ST_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!coreRst_n) begin
      state_q <= CBRSC_ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // card power selections, kept while suspended
  always_ff @(posedge clk) begin
    if (!coreRst_n) begin
      vccSel_q <= CBRSC_VCC_SEL_RST;
      vppSel_q <= CBRSC_VPP_SEL_RST;
    end else if (powerLoad && canUpdate) begin
      vccSel_q <= vccReq;
      vppSel_q <= vppReq;
    end
  end

  // power-event context survives host-bus reset
  always_ff @(posedge clk) begin
    if (!pmeRst_n) begin
      pmeEn_q  <= CBRSC_PME_EN_RST;
      pmeSts_q <= CBRSC_PME_STS_RST;
    end else if (!suspended) begin
      if (pmeEnableSet) begin
        pmeEn_q <= 1'b1;
      end else if (pmeEnableClr) begin
        pmeEn_q <= 1'b0;
      end
      // event wins over clear
      if (pmeEvent) begin
        pmeSts_q <= 1'b1;
      end else if (pmeStatusClr) begin
        pmeSts_q <= 1'b0;
      end
    end
  end

  // ============================================================
  // pins
  always_ff @(posedge clk or negedge coreArst_n) begin
    if (!coreArst_n) begin
      pinOe_n <= 1'b1;
    end else begin
      pinOe_n <= ~driveD;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cardVccSel0 <= 1'b0;
      cardVccSel1 <= 1'b0;
      cardVppSel0 <= 1'b0;
      cardVppSel1 <= 1'b0;
      deviceReady <= 1'b0;
    end else begin
      cardVccSel0 <= vccSel_q[0];
      cardVccSel1 <= vccSel_q[1];
      cardVppSel0 <= vppSel_q[0];
      cardVppSel1 <= vppSel_q[1];
      deviceReady <= driveD;
    end
  end

  // open-drain style: only driven low while an enabled event is pending
  always_ff @(posedge clk) begin
    if (!pmeRst_n) begin
      pmeOut_n <= 1'b1;
      pmeOe_n  <= 1'b1;
    end else begin
      pmeOut_n <= ~pmeAssert;
      pmeOe_n  <= ~(pmeAssert & ~suspended);
    end
  end

  // ============================================================
  // checks
  a_global_floats: assert property (@(posedge clk) disable iff (!resetn)
    (!globalResetIn_n && suspendIn_n) |=> pinOe_n && !deviceReady)
    else $error("outputs not floated under global reset");

  a_global_clears: assert property (@(posedge clk) disable iff (!resetn)
    (!globalResetIn_n && suspendIn_n) |=> (vccSel_q == CBRSC_VCC_SEL_RST)
      && (vppSel_q == CBRSC_VPP_SEL_RST) && !pmeEn_q && !pmeSts_q)
    else $error("registers not cleared by global reset");

  a_susp_keeps: assert property (@(posedge clk) disable iff (!resetn)
    (!suspendIn_n && coreRst_n) |=> $stable(vccSel_q) && $stable(vppSel_q)
      && $stable(pmeEn_q) && $stable(pmeSts_q))
    else $error("registers changed while suspended");

  a_susp_floats: assert property (@(posedge clk) disable iff (!resetn)
    (!suspendIn_n) |=> pinOe_n && pmeOe_n)
    else $error("outputs driven while suspended");

  a_host_floats: assert property (@(posedge clk) disable iff (!resetn)
    (!hostBusResetIn_n && suspendIn_n) |=> pinOe_n
      && (vccSel_q == CBRSC_VCC_SEL_RST) && state_q == CBRSC_ST_RESET)
    else $error("host reset did not float and clear");

  a_pme_gated: assert property (@(posedge clk) disable iff (!resetn)
    !pmeOe_n |-> $past(pmeEn_q) && $past(pmeSts_q) && !pmeOut_n)
    else $error("power event driven without enable");

  a_pme_in_reset: assert property (@(posedge clk) disable iff (!resetn)
    (globalResetIn_n && suspendIn_n && pmeEn_q && pmeSts_q && pmeRst_n)
      |=> !pmeOe_n)
    else $error("enabled power event not driven");

  a_release_dflt: assert property (@(posedge clk) disable iff (!resetn)
    $rose(coreRst_n) |-> (state_q == CBRSC_ST_RESET)
      && (vccSel_q == CBRSC_VCC_SEL_RST) && (vppSel_q == CBRSC_VPP_SEL_RST))
    else $error("not in default state at reset release");

  a_vcc_pins: assert property (@(posedge clk) disable iff (!resetn)
    (powerLoad && canUpdate) ##1 coreRst_n |=> {cardVccSel1, cardVccSel0} == $past(vccReq, 2))
    else $error("supply select pins wrong");

  a_vpp_pins: assert property (@(posedge clk) disable iff (!resetn)
    (powerLoad && canUpdate) ##1 coreRst_n |=> {cardVppSel1, cardVppSel0} == $past(vppReq, 2))
    else $error("programming select pins wrong");

  a_sync_release: assert property (@(posedge clk) disable iff (!resetn)
    (!coreArst_n) |=> !coreRst_n ##1 !coreRst_n)
    else $error("internal reset released too early");

endmodule : cbrsc_ctrl

`default_nettype wire

//--- tb/cbrsc_switch_model.sv
/* card power switch model: turns the four select pins into rail codes.
   assumes: the switch reads floating select pins as rail off. */
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// switch model
module cbrsc_switch_model (
  input  wire logic       pinOe_n,
  input  wire logic       vccSel0,
  input  wire logic       vccSel1,
  input  wire logic       vppSel0,
  input  wire logic       vppSel1,
  output logic      [1:0] supplyRail,
  output logic      [1:0] progRail
);
  assign supplyRail = pinOe_n ? 2'h0 : {vccSel1, vccSel0};
  assign progRail   = pinOe_n ? 2'h0 : {vppSel1, vppSel0};
endmodule : cbrsc_switch_model
`default_nettype wire

//--- tb/tb_cbrsc_ctrl.sv
/* self-checking bench of the reset, suspend and power-switch control.
   assumes: cbrsc_ctrl and the switch model compiled before it. */
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// bench
module tb_cbrsc_ctrl;
  import cbrsc_pkg::*;
  logic clk, resetn, globalResetIn_n, hostBusResetIn_n, suspendIn_n;
  logic powerLoad, pmeEnableSet, pmeEnableClr, pmeEvent, pmeStatusClr;
  logic [1:0] vccReq, vppReq, supplyRail, progRail;
  logic cardVccSel0, cardVccSel1, cardVppSel0, cardVppSel1;
  logic pinOe_n, pmeOut_n, pmeOe_n, deviceReady;
  int   failures, n_compared, cyc;

  cbrsc_ctrl i_dut (.clk, .resetn, .globalResetIn_n, .hostBusResetIn_n, .suspendIn_n,
    .powerLoad, .vccReq, .vppReq, .pmeEnableSet, .pmeEnableClr, .pmeEvent, .pmeStatusClr,
    .cardVccSel0, .cardVccSel1, .cardVppSel0, .cardVppSel1, .pinOe_n, .pmeOut_n,
    .pmeOe_n, .deviceReady);
  cbrsc_switch_model i_sw (.pinOe_n, .vccSel0(cardVccSel0), .vccSel1(cardVccSel1),
    .vppSel0(cardVppSel0), .vppSel1(cardVppSel1), .supplyRail, .progRail);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic ld(input logic [1:0] vc, input logic [1:0] vp);
    @(posedge clk);
    powerLoad <= 1'b1;
    vccReq    <= vc;
    vppReq    <= vp;
    @(posedge clk);
    powerLoad <= 1'b0;
    step(2);
  endtask : ld

  // bounded wait for ready, then pins driven
  task automatic ready_wait;
    for (int i = 0; i < 8 && deviceReady !== 1'b1; i++) step(1);
    chk("ready pinOe_n", 4'h1, {2'h0, pinOe_n, deviceReady});
  endtask : ready_wait

  task automatic pme_arm;
    @(posedge clk);
    pmeEnableSet <= 1'b1;
    @(posedge clk);
    pmeEnableSet <= 1'b0;
    pmeEvent     <= 1'b1;
    @(posedge clk);
    pmeEvent <= 1'b0;
    step(2);
    chk("pme pins", 4'h0, {2'h0, pmeOe_n, pmeOut_n});
  endtask : pme_arm

  task automatic t_boot;
    repeat (3) @(posedge clk);
    resetn          <= 1'b1;
    globalResetIn_n <= 1'b1;
    ready_wait;
    chk("rails", 4'h0, {supplyRail, progRail});
    $display("test boot done");
  endtask : t_boot

  task automatic t_load;
    ld(2'h2, 2'h1);
    chk("rails", 4'h9, {supplyRail, progRail});
    @(posedge clk);
    powerLoad <= 1'b1;
    vccReq    <= 2'h1;
    vppReq    <= 2'h2;
    @(posedge clk);
    vccReq <= 2'h3;
    vppReq <= 2'h0;
    @(posedge clk);
    powerLoad <= 1'b0;
    #1;
    chk("rails", 4'h6, {supplyRail, progRail});
    step(1);
    chk("rails", 4'hC, {supplyRail, progRail});
    $display("test load done");
  endtask : t_load

  task automatic t_host_bus_reset_in;
    pme_arm;
    @(posedge clk);
    hostBusResetIn_n <= 1'b0;
    step(2);
    chk("pinOe_n rails", 4'h8, {pinOe_n, 1'b0, supplyRail});
    chk("pmeOe_n", 4'h0, {3'h0, pmeOe_n});
    @(posedge clk);
    hostBusResetIn_n <= 1'b1;
    ready_wait;
    chk("rails", 4'h0, {supplyRail, progRail});
    @(posedge clk);
    pmeStatusClr <= 1'b1;
    @(posedge clk);
    pmeStatusClr <= 1'b0;
    step(3);
    chk("pmeOe_n", 4'h1, {3'h0, pmeOe_n});
    @(posedge clk);
    pmeEnableClr <= 1'b1;
    @(posedge clk);
    pmeEnableClr <= 1'b0;
    pmeEvent     <= 1'b1;
    @(posedge clk);
    pmeEvent <= 1'b0;
    step(2);
    chk("pme pins", 4'h3, {2'h0, pmeOe_n, pmeOut_n});
    $display("test host reset done");
  endtask : t_host_bus_reset_in

  task automatic t_global_reset_in;
    ld(2'h3, 2'h3);
    pme_arm;
    @(posedge clk);
    globalResetIn_n <= 1'b0;
    step(2);
    chk("pinOe_n pmeOe_n", 4'h3, {2'h0, pinOe_n, pmeOe_n});
    @(posedge clk);
    globalResetIn_n <= 1'b1;
    ready_wait;
    chk("rails pmeOe_n", 4'h1, {supplyRail, 1'b0, pmeOe_n});
    $display("test global reset done");
  endtask : t_global_reset_in

  task automatic t_susp;
    ld(2'h1, 2'h2);
    @(posedge clk);
    suspendIn_n <= 1'b0;
    step(2);
    chk("pinOe_n ready", 4'h2, {2'h0, pinOe_n, deviceReady});
    @(posedge clk);
    globalResetIn_n  <= 1'b0;
    hostBusResetIn_n <= 1'b0;
    step(3);
    chk("pmeOe_n rails", 4'h8, {pmeOe_n, 1'b0, supplyRail});
    @(posedge clk);
    globalResetIn_n  <= 1'b1;
    hostBusResetIn_n <= 1'b1;
    repeat (2) @(posedge clk);
    suspendIn_n <= 1'b1;
    ready_wait;
    chk("rails", 4'h6, {supplyRail, progRail});
    $display("test suspend done");
  endtask : t_susp

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      tally_and_finish;
    end
  end

  initial begin
    {resetn, powerLoad, pmeEnableSet, pmeEnableClr, pmeEvent, pmeStatusClr} = 6'h00;
    {globalResetIn_n, hostBusResetIn_n, suspendIn_n} = 3'h3;
    {vccReq, vppReq} = 4'h0;
    {failures, n_compared, cyc} = '0;
    t_boot;
    t_load;
    t_host_bus_reset_in;
    t_global_reset_in;
    t_susp;
    tally_and_finish;
  end
endmodule : tb_cbrsc_ctrl
`default_nettype wire
